// >>> rtl/dram_timing_select.sv
// DRAM timing select: turns the timing configuration register into leadoff and burst clock counts.
`include "dts_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module dram_timing_select (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [19:0] lead_counts,
    output logic [14:0] pipe_counts,
    output logic [1:0] beat_clks,
    output logic cas_extra_clk,
    output logic ras_extra_clk,
    output logic cs_extra_clk
);
    dts_pkg::dts_state_t s_q;
    dts_pkg::dts_state_t s_d;
    logic sdram;
    logic ecc;
    logic slow;
    logic [4:0] e;
    logic [4:0] w;
    logic [4:0] cl;
    logic [4:0] edo_row_to_col_delay;
    logic [4:0] rp;
    logic req;
    logic [7:0] tn;
    logic [7:0] cn;
    logic wr_try;
    logic [4:0] ecc_add;

    assign req = wb_cyc_i && wb_stb_i && !s_q.ack;
    // A count check looks one edge ahead only when no write can land in between.
    assign wr_try = wb_cyc_i && wb_stb_i && wb_we_i;
    assign ecc_add = {4'h0, s_q.ctrl[`DTS_C_ECC]};

    always_comb begin
        s_d = s_q;
        s_d.ack = req;
        tn = s_q.timing;
        cn = s_q.ctrl;
        if (req && wb_we_i && wb_sel_i[0]) begin
            if (wb_adr_i == `DTS_TIMING_OFS) begin
                tn = wb_dat_i[7:0];
            end
            if (wb_adr_i == `DTS_CTRL_OFS) begin
                cn = {6'h00, wb_dat_i[1:0]};
            end
        end
        s_d.timing = tn;
        s_d.ctrl = cn;
        sdram = cn[`DTS_C_SDRAM];
        ecc = cn[`DTS_C_ECC];
        slow = !tn[`DTS_B_ADDR_WAIT_STATE_SEL];
        e = {4'h0, ecc};
        w = {4'h0, slow};
        if (sdram) begin
            cl = tn[`DTS_B_SDRAM_CAS_LATENCY_SEL] ? 5'h02 : 5'h03;
            edo_row_to_col_delay = tn[`DTS_B_SDRAM_ROW_TO_COL_DELAY] ? 5'h02 : 5'h03;
            rp = tn[`DTS_B_SDRAM_ROW_PRECHARGE_SEL] ? 5'h02 : 5'h03;
            s_d.lead.page_hit_case = `DTS_SD_PH_BASE + cl - 5'h01 + e;
            s_d.lead.row_miss_case = `DTS_SD_RM_BASE + cl + edo_row_to_col_delay - 5'h02 + e;
            s_d.lead.row_miss_close = `DTS_SD_RM_BASE + 5'h01 + cl + edo_row_to_col_delay - 5'h02 + e;
            s_d.lead.page_miss_case = `DTS_SD_RM_BASE + cl + edo_row_to_col_delay + rp - 5'h02 + e;
            s_d.pipe.page_hit_case = `DTS_SD_PIPE_PH_BASE + 5'h03 - cl + e;
            s_d.pipe.row_miss_case = `DTS_SD_PIPE_RM_BASE + cl + edo_row_to_col_delay - 5'h03 + e;
            s_d.pipe.page_miss_case = `DTS_SD_PIPE_RM_BASE + cl + edo_row_to_col_delay + rp - 5'h04 + e;
            s_d.beat_clks = 2'h1;
            s_d.cs_extra = slow;
            s_d.cas_extra = 1'b0;
            s_d.ras_extra = 1'b0;
        end else begin
            edo_row_to_col_delay = 5'h00;
            cl = 5'h00;
            rp = tn[`DTS_B_RPT] ? 5'h00 : 5'h01;
            s_d.lead.page_hit_case = `DTS_EDO_PH_BASE + w + e;
            s_d.lead.row_miss_case = `DTS_EDO_RM_BASE + w + w + e;
            s_d.lead.row_miss_close = `DTS_EDO_RM_BASE + 5'h01 + w + w + e;
            s_d.lead.page_miss_case = `DTS_EDO_RM_BASE + 5'h03 + w + w + rp + e;
            s_d.pipe.page_hit_case = `DTS_EDO_PIPE_PH_BASE + w + e;
            s_d.pipe.row_miss_case = `DTS_EDO_PIPE_RM_BASE + w + e;
            s_d.pipe.page_miss_case = `DTS_EDO_PIPE_RM_BASE + 5'h02 + w + rp + e;
            s_d.beat_clks = (tn[`DTS_B_BURST0] || tn[`DTS_B_BURST1]) ? 2'h3 : 2'h2;
            s_d.cas_extra = slow;
            s_d.ras_extra = slow;
            s_d.cs_extra = 1'b0;
        end
        s_d.dat = 32'h0000_0000;
        if (req && !wb_we_i) begin
            case (wb_adr_i)
                `DTS_TIMING_OFS: s_d.dat = {24'h000000, s_q.timing};
                `DTS_CTRL_OFS: s_d.dat = {24'h000000, s_q.ctrl};
                `DTS_LEAD_OFS: s_d.dat = {12'h000, s_q.lead};
                `DTS_PIPE_OFS: s_d.dat = {17'h00000, s_q.pipe};
                `DTS_BURST_OFS: s_d.dat = {24'h000000, s_q.cs_extra, s_q.ras_extra, s_q.cas_extra,
                    3'h0, s_q.beat_clks};
                default: s_d.dat = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.timing <= `DTS_TIMING_RST;
            s_q.ctrl <= `DTS_CTRL_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign wb_dat_o = s_q.dat;
    assign wb_ack_o = s_q.ack;
    assign lead_counts = s_q.lead;
    assign pipe_counts = s_q.pipe;
    assign beat_clks = s_q.beat_clks;
    assign cas_extra_clk = s_q.cas_extra;
    assign ras_extra_clk = s_q.ras_extra;
    assign cs_extra_clk = s_q.cs_extra;

    property p_ecc_adds;
        @(posedge core_clk) disable iff (!rst_n)
        $rose(s_q.ctrl[`DTS_C_ECC]) && $stable(s_q.timing) && $stable(s_q.ctrl[`DTS_C_SDRAM])
            |-> lead_counts[19:15] == $past(lead_counts[19:15]) + 5'h01;
    endproperty
    a_ecc_adds: assert property (p_ecc_adds) else $error("ecc did not add one clock");
    property p_edo_wait;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && !s_q.timing[`DTS_B_ADDR_WAIT_STATE_SEL] && $stable(s_q.timing) && $stable(s_q.ctrl)
            && !wr_try
            |=> cas_extra_clk && ras_extra_clk && !cs_extra_clk;
    endproperty
    a_edo_wait: assert property (p_edo_wait) else $error("edo wait state missing");
    property p_edo_burst;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && $stable(s_q.timing) && $stable(s_q.ctrl)
            && !wr_try
            |=> beat_clks == (($past(s_q.timing[4:3]) != 2'h0) ? 2'h3 : 2'h2);
    endproperty
    a_edo_burst: assert property (p_edo_burst) else $error("edo burst timing wrong");
    property p_edo_close;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && !wr_try |=> s_q.lead.row_miss_close == s_q.lead.row_miss_case + 5'h01;
    endproperty
    a_edo_close: assert property (p_edo_close) else $error("row close clock missing");
    property p_sd_ph;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl == 8'h01 && s_q.timing == 8'h04 && $stable(s_q.timing) && $stable(s_q.ctrl)
            && !wr_try
            |=> lead_counts[19:15] == 5'h09 && pipe_counts[14:10] == 5'h01;
    endproperty
    a_sd_ph: assert property (p_sd_ph) else $error("sdram page hit count wrong");
    property p_sd_pm;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl == 8'h01 && s_q.timing == 8'h27 && $stable(s_q.timing) && $stable(s_q.ctrl)
            && !wr_try
            |=> lead_counts[4:0] == 5'h0c && pipe_counts[4:0] == 5'h05;
    endproperty
    a_sd_pm: assert property (p_sd_pm) else $error("sdram page miss count wrong");
    property p_sd_wait;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && $stable(s_q.timing) && $stable(s_q.ctrl)
            && !wr_try
            |=> cs_extra_clk == !$past(s_q.timing[`DTS_B_ADDR_WAIT_STATE_SEL]) && beat_clks == 2'h1;
    endproperty
    a_sd_wait: assert property (p_sd_wait) else $error("sdram chip select wait wrong");
    property p_edo_rm;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl == 8'h00 && s_q.timing == 8'h00 && $stable(s_q.timing) && $stable(s_q.ctrl)
            && !wr_try
            |=> lead_counts == {5'h09, 5'h0c, 5'h0d, 5'h10};
    endproperty
    a_edo_rm: assert property (p_edo_rm) else $error("edo leadoff table wrong");
    sequence s_bus_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    property p_ack;
        @(posedge core_clk) disable iff (!rst_n)
        s_bus_take |=> s_ack_pulse;
    endproperty
    a_ack: assert property (p_ack) else $error("bus ack timing wrong");

    // Register bus side effects.
    property p_dat_idle;
        @(posedge core_clk) disable iff (!rst_n)
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");

    property p_ctrl_pad;
        @(posedge core_clk) disable iff (!rst_n)
        1'b1 |-> s_q.ctrl[7:2] == 6'h00;
    endproperty
    a_ctrl_pad: assert property (p_ctrl_pad) else $error("control upper bits set");

    property p_rd_timing;
        @(posedge core_clk) disable iff (!rst_n)
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == `DTS_TIMING_OFS
            |=> wb_dat_o == {24'h000000, $past(s_q.timing)};
    endproperty
    a_rd_timing: assert property (p_rd_timing) else $error("timing readback wrong");

    property p_sel_gate;
        @(posedge core_clk) disable iff (!rst_n)
        wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !wb_sel_i[0]
            |=> $stable(s_q.timing) && $stable(s_q.ctrl);
    endproperty
    a_sel_gate: assert property (p_sel_gate) else $error("write without low byte lane");

    property p_edo_no_cs;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && !wr_try |=> !cs_extra_clk;
    endproperty
    a_edo_no_cs: assert property (p_edo_no_cs) else $error("edo chip select wait set");

    property p_sd_no_strobe;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && !wr_try |=> !cas_extra_clk && !ras_extra_clk;
    endproperty
    a_sd_no_strobe: assert property (p_sd_no_strobe) else $error("sdram strobe wait set");

    // EDO table rows; only the wait, precharge and ECC bits change the counts.
    property p_edo_row_a;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h24) == 8'h24 && !wr_try
            |=> lead_counts == {5'h08 + ecc_add, 5'h0a + ecc_add, 5'h0b + ecc_add, 5'h0d + ecc_add}
            && pipe_counts == {5'h02 + ecc_add, 5'h06 + ecc_add, 5'h08 + ecc_add};
    endproperty
    a_edo_row_a: assert property (p_edo_row_a) else $error("edo row a counts wrong");

    property p_edo_row_b;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h24) == 8'h04 && !wr_try
            |=> lead_counts == {5'h08 + ecc_add, 5'h0a + ecc_add, 5'h0b + ecc_add, 5'h0e + ecc_add}
            && pipe_counts == {5'h02 + ecc_add, 5'h06 + ecc_add, 5'h09 + ecc_add};
    endproperty
    a_edo_row_b: assert property (p_edo_row_b) else $error("edo row b counts wrong");

    property p_edo_row_c;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h24) == 8'h20 && !wr_try
            |=> lead_counts == {5'h09 + ecc_add, 5'h0c + ecc_add, 5'h0d + ecc_add, 5'h0f + ecc_add}
            && pipe_counts == {5'h03 + ecc_add, 5'h07 + ecc_add, 5'h09 + ecc_add};
    endproperty
    a_edo_row_c: assert property (p_edo_row_c) else $error("edo row c counts wrong");

    property p_edo_row_d;
        @(posedge core_clk) disable iff (!rst_n)
        !s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h24) == 8'h00 && !wr_try
            |=> lead_counts == {5'h09 + ecc_add, 5'h0c + ecc_add, 5'h0d + ecc_add, 5'h10 + ecc_add}
            && pipe_counts == {5'h03 + ecc_add, 5'h07 + ecc_add, 5'h0a + ecc_add};
    endproperty
    a_edo_row_d: assert property (p_edo_row_d) else $error("edo row d counts wrong");

    // SDRAM table rows, all with the fast address wait.
    property p_sd_row_a;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h27 && !wr_try
            |=> lead_counts == {5'h08 + ecc_add, 5'h0a + ecc_add, 5'h0b + ecc_add, 5'h0c + ecc_add}
            && pipe_counts == {5'h02 + ecc_add, 5'h04 + ecc_add, 5'h05 + ecc_add};
    endproperty
    a_sd_row_a: assert property (p_sd_row_a) else $error("sdram row a counts wrong");

    property p_sd_row_b;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h07 && !wr_try
            |=> lead_counts == {5'h08 + ecc_add, 5'h0a + ecc_add, 5'h0b + ecc_add, 5'h0d + ecc_add}
            && pipe_counts == {5'h02 + ecc_add, 5'h04 + ecc_add, 5'h06 + ecc_add};
    endproperty
    a_sd_row_b: assert property (p_sd_row_b) else $error("sdram row b counts wrong");

    property p_sd_row_c;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h26 && !wr_try
            |=> lead_counts == {5'h09 + ecc_add, 5'h0b + ecc_add, 5'h0c + ecc_add, 5'h0d + ecc_add}
            && pipe_counts == {5'h01 + ecc_add, 5'h05 + ecc_add, 5'h06 + ecc_add};
    endproperty
    a_sd_row_c: assert property (p_sd_row_c) else $error("sdram row c counts wrong");

    property p_sd_row_d;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h25 && !wr_try
            |=> lead_counts == {5'h08 + ecc_add, 5'h0b + ecc_add, 5'h0c + ecc_add, 5'h0d + ecc_add}
            && pipe_counts == {5'h02 + ecc_add, 5'h05 + ecc_add, 5'h06 + ecc_add};
    endproperty
    a_sd_row_d: assert property (p_sd_row_d) else $error("sdram row d counts wrong");

    property p_sd_row_e;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h06 && !wr_try
            |=> lead_counts == {5'h09 + ecc_add, 5'h0b + ecc_add, 5'h0c + ecc_add, 5'h0e + ecc_add}
            && pipe_counts == {5'h01 + ecc_add, 5'h05 + ecc_add, 5'h07 + ecc_add};
    endproperty
    a_sd_row_e: assert property (p_sd_row_e) else $error("sdram row e counts wrong");

    property p_sd_row_f;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h04 && !wr_try
            |=> lead_counts == {5'h09 + ecc_add, 5'h0c + ecc_add, 5'h0d + ecc_add, 5'h0f + ecc_add}
            && pipe_counts == {5'h01 + ecc_add, 5'h06 + ecc_add, 5'h08 + ecc_add};
    endproperty
    a_sd_row_f: assert property (p_sd_row_f) else $error("sdram row f counts wrong");

    property p_sd_row_g;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h05 && !wr_try
            |=> lead_counts == {5'h08 + ecc_add, 5'h0b + ecc_add, 5'h0c + ecc_add, 5'h0e + ecc_add}
            && pipe_counts == {5'h02 + ecc_add, 5'h05 + ecc_add, 5'h07 + ecc_add};
    endproperty
    a_sd_row_g: assert property (p_sd_row_g) else $error("sdram row g counts wrong");

    property p_sd_row_h;
        @(posedge core_clk) disable iff (!rst_n)
        s_q.ctrl[`DTS_C_SDRAM] && (s_q.timing & 8'h27) == 8'h24 && !wr_try
            |=> lead_counts == {5'h09 + ecc_add, 5'h0c + ecc_add, 5'h0d + ecc_add, 5'h0e + ecc_add}
            && pipe_counts == {5'h01 + ecc_add, 5'h06 + ecc_add, 5'h07 + ecc_add};
    endproperty
    a_sd_row_h: assert property (p_sd_row_h) else $error("sdram row h counts wrong");
endmodule : dram_timing_select
`default_nettype wire

// >>> rtl/dts_regs.svh
// Register offsets, field positions, reset values and timing counts of the DRAM timing select block.
`ifndef DTS_REGS_SVH
`define DTS_REGS_SVH
`define DTS_TIMING_OFS 8'h58
`define DTS_CTRL_OFS 8'h5c
`define DTS_LEAD_OFS 8'h60
`define DTS_PIPE_OFS 8'h64
`define DTS_BURST_OFS 8'h68
`define DTS_B_EDO_RCD 1
`define DTS_B_ADDR_WAIT_STATE_SEL 2
`define DTS_B_BURST0 3
`define DTS_B_BURST1 4
`define DTS_B_RPT 5
`define DTS_B_SDRAM_CAS_LATENCY_SEL 0
`define DTS_B_SDRAM_ROW_TO_COL_DELAY 1
`define DTS_B_SDRAM_ROW_PRECHARGE_SEL 5
`define DTS_C_SDRAM 0
`define DTS_C_ECC 1
`define DTS_TIMING_RST 8'h00
`define DTS_CTRL_RST 8'h00
`define DTS_EDO_PH_BASE 5'h08
`define DTS_EDO_RM_BASE 5'h0a
`define DTS_EDO_PIPE_PH_BASE 5'h02
`define DTS_EDO_PIPE_RM_BASE 5'h06
`define DTS_SD_PH_BASE 5'h07
`define DTS_SD_RM_BASE 5'h08
`define DTS_SD_PIPE_PH_BASE 5'h01
`define DTS_SD_PIPE_RM_BASE 5'h03
`endif

// >>> rtl/dts_pkg.sv
// Types shared by the DRAM timing select block.
package dts_pkg;
    typedef struct packed {
        logic [4:0] page_hit_case;
        logic [4:0] row_miss_case;
        logic [4:0] row_miss_close;
        logic [4:0] page_miss_case;
    } dts_lead_t;
    typedef struct packed {
        logic [4:0] page_hit_case;
        logic [4:0] row_miss_case;
        logic [4:0] page_miss_case;
    } dts_pipe_t;
    typedef struct packed {
        logic [7:0] timing;
        logic [7:0] ctrl;
        dts_lead_t lead;
        dts_pipe_t pipe;
        logic [1:0] beat_clks;
        logic cas_extra;
        logic ras_extra;
        logic cs_extra;
        logic [31:0] dat;
        logic ack;
    } dts_state_t;
endpackage : dts_pkg

// >>> bench/dts_dram_model.sv
// Memory device side model: clocks taken by a four-beat page-hit burst under the chosen timing.
`timescale 1ns/1ps
`default_nettype none
module dts_dram_model (
    input wire logic core_clk,
    input wire logic [19:0] lead_counts,
    input wire logic [1:0] beat_clks,
    output logic [6:0] burst_clks
);
    // The device sees the first beat after the leadoff, then three later beats.
    always_ff @(posedge core_clk) begin
        burst_clks <= 7'(lead_counts[19:15]) + 7'(beat_clks) * 7'h3;
    end
endmodule : dts_dram_model
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking testbench of the DRAM timing select block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic core_clk, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, cas_x, ras_x, cs_x;
    logic [7:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, lfsr;
    logic [19:0] lead_counts;
    logic [14:0] pipe_counts;
    logic [1:0] beat_clks;
    logic [6:0] burst_clks;
    int fails = 0, n_checks = 0, cyc_cnt = 0;
    dram_timing_select i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .lead_counts(lead_counts), .pipe_counts(pipe_counts), .beat_clks(beat_clks),
        .cas_extra_clk(cas_x), .ras_extra_clk(ras_x), .cs_extra_clk(cs_x));
    dts_dram_model i_mem (.core_clk(core_clk), .lead_counts(lead_counts), .beat_clks(beat_clks),
        .burst_clks(burst_clks));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand
    // Packs {page hit, row miss, row miss closing, page miss, pipelined x3, beat, cs, ras, cas}.
    function automatic logic [39:0] exp_out(input logic [7:0] t, input logic [7:0] c);
        logic [4:0] s, e, ph, rm, pm, pph, prm, ppm;
        logic [1:0] bt;
        s = 5'(!t[2]);
        e = 5'(c[1]);
        if (c[0]) begin
            ph = 5'h08 + 5'(!t[0]);
            rm = 5'h0a + 5'(!t[0]) + 5'(!t[1]);
            pm = rm + 5'h02 + 5'(!t[5]);
            pph = 5'h01 + 5'(t[0]);
            prm = 5'h04 + 5'(!t[0]) + 5'(!t[1]);
            ppm = prm + 5'h01 + 5'(!t[5]);
            bt = 2'h1;
        end else begin
            ph = 5'h08 + s;
            rm = 5'h0a + s + s;
            pm = rm + 5'h03 + 5'(!t[5]);
            pph = 5'h02 + s;
            prm = 5'h06 + s;
            ppm = prm + 5'h02 + 5'(!t[5]);
            bt = (t[3] | t[4]) ? 2'h3 : 2'h2;
        end
        return {ph + e, rm + e, rm + e + 5'h01, pm + e, pph + e, prm + e, ppm + e, bt,
            c[0] & s[0], !c[0] & s[0], !c[0] & s[0]};
    endfunction : exp_out
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    // One classic cycle, then two idle edges so the model has taken the new counts.
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= s;
        do begin
            @(posedge core_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        q = wb_dat_o;
        if (n >= 50) chk(40'h1, 40'h0);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        repeat (2) @(posedge core_clk);
    endtask : wb
    always @(posedge core_clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        logic [31:0] q;
        logic [39:0] e, m;
        logic [7:0] t, c;
        lfsr = 32'h0d5f957f;
        {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        chk({lead_counts, pipe_counts, beat_clks, cs_x, ras_x, cas_x}, exp_out(8'h00, 8'h00));
        wb(1'b0, 8'h60, 32'h0, 4'hf, q);
        chk(40'(q), 40'(exp_out(8'h00, 8'h00) >> 20));
        wb(1'b0, 8'h7c, 32'h0, 4'hf, q);
        chk(40'(q), 40'h0);
        wb(1'b1, 8'h58, 32'h0000_00ff, 4'he, q);
        wb(1'b0, 8'h58, 32'h0, 4'hf, q);
        chk(40'(q), 40'h0);
        // Corner cases: every table row of both memory kinds.
        for (int k = 0; k < 12; k++) begin
            lfsr = next_rand(lfsr);
            c = {6'h0, lfsr[0], k < 8};
            t = (k < 8) ? {2'h0, k[2], 2'h0, 1'b1, k[1:0]} : {2'h0, k[0], 2'h0, k[1], 2'h0};
            wb(1'b1, 8'h5c, {24'h0, c}, 4'hf, q);
            wb(1'b1, 8'h58, {24'h0, t}, 4'hf, q);
            chk({lead_counts, pipe_counts, beat_clks, cs_x, ras_x, cas_x}, exp_out(t, c));
        end
        for (int i = 0; i < 64; i++) begin
            lfsr = next_rand(lfsr);
            t = lfsr[7:0];
            c = {6'h0, lfsr[9:8]};
            if (!c[0]) t[1] = 1'b0;
            e = exp_out(t, c);
            m = {40{1'b1}};
            wb(1'b1, 8'h5c, {lfsr[31:8], c}, 4'hf, q);
            wb(1'b1, 8'h58, {lfsr[31:8], t}, 4'hf, q);
            chk({lead_counts, pipe_counts, beat_clks, cs_x, ras_x, cas_x} & m, e & m);
            wb(1'b0, 8'h58, 32'h0, 4'hf, q);
            chk(40'(q), 40'(t));
            if (m[3]) begin
                chk(40'(burst_clks), 40'(e[39:35]) + 40'(e[4:3]) * 40'h3);
                wb(1'b0, 8'h68, 32'h0, 4'hf, q);
                chk(40'(q), {32'h0, e[2:0], 3'h0, e[4:3]});
            end
        end
        finish_test();
    end
endmodule : testbench
`default_nettype wire
